// *** common/iag_pkg.sv ***
// Constants shared by the indirect address generator
package iag_pkg;
    localparam int unsigned WORD_W        = 16;
    localparam int unsigned PTR_COUNT     = 8;
    localparam int unsigned SEL_W         = 3;
    // Instruction word fields
    localparam int unsigned OPCODE_HI     = 15;
    localparam int unsigned OPCODE_LO     = 8;
    localparam int unsigned MODE_BIT      = 7;
    localparam int unsigned STEP_SRC_BIT  = 6;
    localparam int unsigned PLUS_BIT      = 5;
    localparam int unsigned MINUS_BIT     = 4;
    localparam int unsigned SEL_CHG_BIT   = 3;
    localparam int unsigned NEXT_PTR_HI   = 2;
    localparam int unsigned NEXT_PTR_LO   = 0;
    // Update codes: step source, plus, minus
    localparam logic [2:0] CODE_NONE      = 3'h0;
    localparam logic [2:0] CODE_DEC1      = 3'h1;
    localparam logic [2:0] CODE_INC1      = 3'h2;
    localparam logic [2:0] CODE_RSVD      = 3'h3;
    localparam logic [2:0] CODE_RC_SUB    = 3'h4;
    localparam logic [2:0] CODE_SUB       = 3'h5;
    localparam logic [2:0] CODE_ADD       = 3'h6;
    localparam logic [2:0] CODE_RC_ADD    = 3'h7;
    // Register map, byte addresses
    localparam logic [7:0] PTR_BASE_OFS   = 8'h00;
    localparam logic [7:0] STEP_OFS       = 8'h20;
    localparam logic [7:0] STATUS_OFS     = 8'h24;
    localparam logic [7:0] LAST_INSTR_OFS = 8'h28;
    localparam int unsigned ADDR_W        = 8;
    // status_word_one layout
    localparam int unsigned SEL_LSB       = 0;
    localparam int unsigned BACKUP_LSB    = 8;
    // Reset values and AXI response codes
    localparam logic [15:0] PTR_RESET     = 16'h0000;
    localparam logic [15:0] STEP_RESET    = 16'h0000;
    localparam logic [2:0]  SEL_RESET     = 3'h0;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    typedef enum logic [2:0] {
        op_none, op_dec1, op_inc1, op_sub, op_add, op_rc_sub, op_rc_add
    } update_op_type;
endpackage : iag_pkg

// *** rtl/indirect_address_generator.sv ***
// Indirect address decode and pointer arithmetic with an AXI4-Lite slave
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// (RL1) Bits 15..8 are the eight-bit opcode, whatever the addressing mode.
// (RL2) Bit 7 selects mode: zero direct, one indirect with update fields.
// (RL3) Bit 6 picks the amount: one when clear, step register when set.
// (RL4) Bit 5 asks for an increase of the current pointer register.
// (RL5) Bit 4 asks for a decrease; with bit 5 it fixes the operation.
// (RL6) Bit 3 set loads the selector and saves the old one in backup.
// (RL7) Bits 2..0 are the next pointer value, loaded only when bit 3 set.
// (RL8) Code 000 accesses at the current pointer and leaves it unchanged.
// (RL9) Code 001 decrements by one, code 010 increments by one.
// (RL10) Code 101 subtracts step, code 110 adds step, normal carry.
// (RL11) Code 111 adds step, code 100 subtracts step, reverse carry.
// (RL12) Indirect decode applies only to instructions with a memory operand.
// (RL13) A selector change takes effect from the following instruction.
// (RL14) Word 28ABh decodes as increment by one and select pointer three.
// (RL15) Word 28F0h decodes as a reverse-carry add of the step register.
// (RL16) Repeated reverse-carry adds of half the FFT size give bit order.
// (RL17) Base 0110 0000 step 0000 1000 yields 0110 1000, 0110 0100, ...
// (RL18) The operand address is the current pointer before its update.
// (RL19) Pointer arithmetic is unsigned sixteen-bit, wrapping.
// (RL20) Reverse carry runs from the top bit toward the bottom bit.
// (RL21) The selector holds 0..7 and picks one of eight pointers.
// (RL22) Reserved code 011 leaves the current pointer unchanged.
module indirect_address_generator
    import iag_pkg::*;
(
    input  wire logic                aclk,
    input  wire logic                aresetn,
    // Instruction decode side
    input  wire logic                instr_valid,
    input  wire logic [WORD_W-1:0]   instr_word,
    input  wire logic                instr_has_mem,
    output var  logic                decode_valid,
    output var  logic [7:0]          opcode,
    output var  logic                indirect_access,
    output var  logic [WORD_W-1:0]   mem_addr,
    // AXI4-Lite slave
    input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output var  logic                s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output var  logic                s_axi_wready,
    output var  logic [1:0]          s_axi_bresp,
    output var  logic                s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output var  logic                s_axi_arready,
    output var  logic [31:0]         s_axi_rdata,
    output var  logic [1:0]          s_axi_rresp,
    output var  logic                s_axi_rvalid,
    input  wire logic                s_axi_rready
);

    // Bit reversal lets the ordinary adder run with reverse carry
    function automatic logic [WORD_W-1:0] rev(input logic [WORD_W-1:0] v);
        logic [WORD_W-1:0] r;
        r = '0;
        for (int i = 0; i < WORD_W; i++) begin
            r[i] = v[WORD_W-1-i];
        end
        return r;
    endfunction : rev

    function automatic logic [WORD_W-1:0] rc_add(
        input logic [WORD_W-1:0] a,
        input logic [WORD_W-1:0] b
    );
        return rev(rev(a) + rev(b));
    endfunction : rc_add

    function automatic logic [WORD_W-1:0] rc_sub(
        input logic [WORD_W-1:0] a,
        input logic [WORD_W-1:0] b
    );
        return rev(rev(a) - rev(b));
    endfunction : rc_sub

    function automatic logic [15:0] merge16(
        input logic [15:0] old,
        input logic [31:0] data,
        input logic [3:0]  strb
    );
        logic [15:0] r;
        r = old;
        if (strb[0]) begin
            r[7:0] = data[7:0];
        end
        if (strb[1]) begin
            r[15:8] = data[15:8];
        end
        return r;
    endfunction : merge16

    function automatic update_op_type decode_op(input logic [2:0] code);
        update_op_type op;
        op = op_none;
        unique case (code)
            CODE_NONE:   op = op_none;
            CODE_DEC1:   op = op_dec1;
            CODE_INC1:   op = op_inc1;
            CODE_RSVD:   op = op_none;
            CODE_RC_SUB: op = op_rc_sub;
            CODE_SUB:    op = op_sub;
            CODE_ADD:    op = op_add;
            CODE_RC_ADD: op = op_rc_add;
        endcase
        return op;
    endfunction : decode_op

    logic [WORD_W-1:0]  pointer_registers [PTR_COUNT];
    logic [WORD_W-1:0]  step_register;
    logic [SEL_W-1:0]   pointer_selector;
    logic [SEL_W-1:0]   pointer_backup;
    logic [WORD_W-1:0]  last_instr;

    logic               take;
    logic [2:0]         upd_code;
    update_op_type      upd_op;
    logic [WORD_W-1:0]  cur_ptr;
    logic [WORD_W-1:0]  next_ptr;
    logic [SEL_W-1:0]   next_pointer_value;

    // Only indirect words with a memory operand touch the pointers
    assign take = instr_valid && instr_has_mem
                  && instr_word[MODE_BIT];                 // see (RL2) (RL12)
    assign upd_code = {instr_word[STEP_SRC_BIT], instr_word[PLUS_BIT],
                       instr_word[MINUS_BIT]};             // see (RL3) (RL4)
    assign upd_op = decode_op(upd_code);                   // see (RL5) (RL15)
    assign cur_ptr = pointer_registers[pointer_selector];  // see (RL21)
    assign next_pointer_value = instr_word[NEXT_PTR_HI:NEXT_PTR_LO];

    always_comb begin
        next_ptr = cur_ptr;                        // see (RL8) (RL22)
        unique case (upd_op)
            op_none:   next_ptr = cur_ptr;
            op_dec1:   next_ptr = cur_ptr - 16'h0001;       // see (RL9)
            op_inc1:   next_ptr = cur_ptr + 16'h0001;       // see (RL9)
            op_sub:    next_ptr = cur_ptr - step_register;  // see (RL10)
            op_add:    next_ptr = cur_ptr + step_register;  // see (RL19)
            op_rc_sub: next_ptr = rc_sub(cur_ptr, step_register); // see (RL11)
            op_rc_add: next_ptr = rc_add(cur_ptr, step_register); // see (RL20)
        endcase
    end

    // AXI4-Lite write side: address and data taken in either order
    logic               aw_held;
    logic               w_held;
    logic [ADDR_W-1:0]  aw_addr;
    logic [31:0]        w_data;
    logic [3:0]         w_strb;
    logic               wr_commit;
    logic               wr_ptr_hit;
    logic               wr_step_hit;
    logic               wr_stat_hit;
    logic [2:0]         wr_idx;

    assign wr_commit   = aw_held && w_held && !s_axi_bvalid;
    assign wr_idx      = aw_addr[4:2];
    assign wr_ptr_hit  = (aw_addr[7:5] == PTR_BASE_OFS[7:5])
                         && (aw_addr[1:0] == 2'h0);
    assign wr_step_hit = (aw_addr == STEP_OFS);
    assign wr_stat_hit = (aw_addr == STATUS_OFS);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= '0;
            w_data        <= '0;
            w_strb        <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_commit) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_ptr_hit || wr_step_hit || wr_stat_hit)
                                ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
            end
        end
    end

    // Pointer file; a bus write to the same register beats the update
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < PTR_COUNT; i++) begin
                pointer_registers[i] <= PTR_RESET;
            end
        end else begin
            if (take) begin
                pointer_registers[pointer_selector] <= next_ptr; // see (RL13)
            end
            if (wr_commit && wr_ptr_hit) begin
                pointer_registers[wr_idx] <=
                    merge16(pointer_registers[wr_idx], w_data, w_strb);
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            step_register <= STEP_RESET;
        end else if (wr_commit && wr_step_hit) begin
            // Holds half the FFT size for bit-reversed walks, see (RL16)
            step_register <= merge16(step_register, w_data, w_strb);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pointer_selector <= SEL_RESET;
            pointer_backup   <= SEL_RESET;
        end else if (wr_commit && wr_stat_hit && w_strb[0]) begin
            pointer_selector <= w_data[SEL_LSB +: SEL_W];
            if (w_strb[1]) begin
                pointer_backup <= w_data[BACKUP_LSB +: SEL_W];
            end
        end else if (take && instr_word[SEL_CHG_BIT]) begin
            pointer_selector <= next_pointer_value; // see (RL6) (RL7) (RL14)
            pointer_backup   <= pointer_selector;            // see (RL6)
        end
    end

    // Decode outputs, registered one cycle after the word is offered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            decode_valid    <= 1'b0;
            opcode          <= '0;
            indirect_access <= 1'b0;
            mem_addr        <= '0;
            last_instr      <= '0;
        end else begin
            decode_valid    <= instr_valid;
            indirect_access <= take;
            if (instr_valid) begin
                opcode     <= instr_word[OPCODE_HI:OPCODE_LO]; // see (RL1)
                last_instr <= instr_word;
            end
            if (take) begin
                mem_addr <= cur_ptr;                         // see (RL18)
            end
        end
    end

    // AXI4-Lite read side
    logic [31:0] rd_word;
    logic        rd_hit;

    always_comb begin
        rd_word = '0;
        rd_hit  = 1'b1;
        if ((s_axi_araddr[7:5] == PTR_BASE_OFS[7:5])
            && (s_axi_araddr[1:0] == 2'h0)) begin
            rd_word[15:0] = pointer_registers[s_axi_araddr[4:2]];
        end else if (s_axi_araddr == STEP_OFS) begin
            rd_word[15:0] = step_register;
        end else if (s_axi_araddr == STATUS_OFS) begin
            rd_word[SEL_LSB +: SEL_W]    = pointer_selector;
            rd_word[BACKUP_LSB +: SEL_W] = pointer_backup;
        end else if (s_axi_araddr == LAST_INSTR_OFS) begin
            rd_word[15:0] = last_instr;
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid
                             && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Checks on the decode, the pointer arithmetic and the write response
    logic quiet;
    assign quiet = !wr_commit;

    property p_opcode_field;
        @(posedge aclk) disable iff (!aresetn)
        instr_valid |=> decode_valid && opcode == $past(instr_word[15:8]);
    endproperty
    a_opcode_field: assert property (p_opcode_field) // see (RL1)
        else $error("opcode field not passed through");

    property p_direct_no_access;
        @(posedge aclk) disable iff (!aresetn)
        instr_valid && (!instr_word[MODE_BIT] || !instr_has_mem) && quiet
        |=> !indirect_access && $stable(pointer_selector);
    endproperty
    a_direct_no_access: assert property (p_direct_no_access) // see (RL12)
        else $error("direct or immediate word touched the pointers");

    property p_addr_before_update;
        @(posedge aclk) disable iff (!aresetn)
        take |=> indirect_access && mem_addr == $past(cur_ptr);
    endproperty
    a_addr_before_update: assert property (p_addr_before_update) // see (RL18)
        else $error("operand address is not the pre-update pointer");

    property p_step_one;
        @(posedge aclk) disable iff (!aresetn)
        take && quiet && upd_code == CODE_INC1
        |=> pointer_registers[$past(pointer_selector)]
            == 16'($past(cur_ptr) + 16'h0001);
    endproperty
    a_step_one: assert property (p_step_one) // see (RL9)
        else $error("increment by one wrong");

    property p_step_sub;
        @(posedge aclk) disable iff (!aresetn)
        take && quiet && upd_code == CODE_SUB
        |=> pointer_registers[$past(pointer_selector)]
            == 16'($past(cur_ptr) - $past(step_register));
    endproperty
    a_step_sub: assert property (p_step_sub) // see (RL10)
        else $error("subtract step wrong");

    property p_hold;
        @(posedge aclk) disable iff (!aresetn)
        take && quiet && (upd_code == CODE_NONE || upd_code == CODE_RSVD)
        |=> pointer_registers[$past(pointer_selector)] == $past(cur_ptr);
    endproperty
    a_hold: assert property (p_hold) // see (RL22)
        else $error("pointer changed on a hold code");

    property p_rc_add;
        @(posedge aclk) disable iff (!aresetn)
        take && quiet && upd_code == CODE_RC_ADD && cur_ptr == 16'h0060
        && step_register == 16'h0008 |=> cur_ptr == 16'h0068;
    endproperty
    a_rc_add: assert property (p_rc_add) // see (RL17)
        else $error("reverse carry add wrong");

    property p_sel_change;
        @(posedge aclk) disable iff (!aresetn)
        take && quiet && instr_word[SEL_CHG_BIT]
        |=> pointer_selector == $past(instr_word[2:0])
            && pointer_backup == $past(pointer_selector);
    endproperty
    a_sel_change: assert property (p_sel_change) // see (RL6)
        else $error("selector switch or backup wrong");

    property p_bresp_stable;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bresp_stable: assert property (p_bresp_stable)
        else $error("write response dropped before taken");

endmodule : indirect_address_generator

`default_nettype wire

// *** verif/decode_stage_model.sv ***
// Model of the instruction decode stage that feeds the address generator
`timescale 1ns/10ps
`default_nettype none
module decode_stage_model (
    input  wire logic        aclk,
    output var  logic        instr_valid,
    output var  logic [15:0] instr_word,
    output var  logic        instr_has_mem
);
    initial begin
        instr_valid   = 1'b0;
        instr_word    = 16'h0000;
        instr_has_mem = 1'b0;
    end

    // Called just after a rising edge; the word stands until idle
    task automatic drive(input logic [15:0] w, input logic m);
        instr_valid   <= 1'b1;
        instr_word    <= w;
        instr_has_mem <= m;
    endtask : drive

    // A stale word is inverted so nothing can lean on it
    task automatic idle();
        instr_valid <= 1'b0;
        instr_word  <= ~instr_word;
    endtask : idle
endmodule : decode_stage_model
`default_nettype wire

// *** verif/tb_indirect_address_generator.sv ***
// Self-checking testbench for the indirect address generator
`timescale 1ns/10ps
`default_nettype none
module tb_indirect_address_generator;
    import iag_pkg::*;
    logic        aclk, aresetn, instr_valid, instr_has_mem;
    logic [15:0] instr_word, mem_addr;
    logic        decode_valid, indirect_access;
    logic [7:0]  opcode, s_axi_awaddr, s_axi_araddr;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    int          error_cnt, n_tests, cycles;

    decode_stage_model p (.aclk(aclk), .instr_valid(instr_valid),
        .instr_word(instr_word), .instr_has_mem(instr_has_mem));

    indirect_address_generator dut (.aclk(aclk), .aresetn(aresetn),
        .instr_valid(instr_valid), .instr_word(instr_word),
        .instr_has_mem(instr_has_mem), .decode_valid(decode_valid),
        .opcode(opcode), .indirect_access(indirect_access),
        .mem_addr(mem_addr), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    task automatic stop_test();
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test

    // Generous ceiling: the whole sequence needs well under 2000 cycles
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            stop_test();
        end
    end

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // AW and W offered together; B may come at any edge from here on
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        logic aw_ok, w_ok, b_ok;
        aw_ok = 1'b0;
        w_ok  = 1'b0;
        b_ok  = 1'b0;
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= 4'hf;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!b_ok) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
            if (s_axi_bvalid === 1'b1) begin
                b_ok = 1'b1;
                r = s_axi_bresp;
            end
        end
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        logic r_ok;
        r_ok = 1'b0;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        while (!r_ok) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
            end
            if (s_axi_rvalid === 1'b1) begin
                r_ok = 1'b1;
                d = s_axi_rdata;
                r = s_axi_rresp;
            end
        end
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : rd

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        wr(a, d, r);
        check("write resp", {30'h0, r}, {30'h0, RESP_OKAY});
    endtask : wreg

    task automatic rchk(input string nm, input logic [7:0] a,
                        input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        check(nm, d, exp);
        check("read resp", {30'h0, r}, {30'h0, RESP_OKAY});
    endtask : rchk

    // Returns at the edge where the answer to the word is sampled
    task automatic issue(input logic [15:0] w, input logic m);
        p.drive(w, m);
        @(posedge aclk);
        p.idle();
        @(posedge aclk);
    endtask : issue

    task automatic dchk(input logic [7:0] op, input logic ind,
                        input logic [15:0] a);
        check("decode_valid", {31'h0, decode_valid}, 32'h1);
        check("opcode", {24'h0, opcode}, {24'h0, op});
        check("indirect", {31'h0, indirect_access}, {31'h0, ind});
        if (ind) check("mem_addr", {16'h0, mem_addr}, {16'h0, a});
    endtask : dchk

    function automatic logic [15:0] rev(input logic [15:0] v);
        for (int i = 0; i < 16; i++) rev[i] = v[15-i];
    endfunction : rev

    function automatic logic [15:0] upd(input logic [2:0] c,
                                        input logic [15:0] a, s);
        case (c)
            CODE_DEC1:   return a - 16'h0001;
            CODE_INC1:   return a + 16'h0001;
            CODE_RC_SUB: return rev(rev(a) - rev(s));
            CODE_SUB:    return a - s;
            CODE_ADD:    return a + s;
            CODE_RC_ADD: return rev(rev(a) + rev(s));
            default:     return a;
        endcase
    endfunction : upd

    task automatic test_reset();
        logic [31:0] d;
        logic [1:0]  r;
        for (int i = 0; i < 8; i++) rchk("ptr rst", 8'(i * 4), 32'h0);
        rchk("step rst", STEP_OFS, 32'h0);
        rchk("status rst", STATUS_OFS, 32'h0);
        rd(8'h40, d, r);
        check("unmapped rresp", {30'h0, r}, {30'h0, RESP_SLVERR});
        check("unmapped rdata", d, 32'h0);
        wr(LAST_INSTR_OFS, 32'h1234, r);
        check("ro bresp", {30'h0, r}, {30'h0, RESP_SLVERR});
    endtask : test_reset

    task automatic test_encoding();
        wreg(PTR_BASE_OFS, 32'h0010);
        wreg(8'h0c, 32'h0500);
        issue(16'h28ab, 1'b1);
        dchk(8'h28, 1'b1, 16'h0010);
        rchk("ptr0", PTR_BASE_OFS, 32'h0011);
        rchk("status", STATUS_OFS, 32'h0003);
        issue(16'h2880, 1'b1);
        dchk(8'h28, 1'b1, 16'h0500);
        issue(16'h2888, 1'b1);
        dchk(8'h28, 1'b1, 16'h0500);
        rchk("ptr3", 8'h0c, 32'h0500);
        rchk("backup", STATUS_OFS, 32'h0300);
    endtask : test_encoding

    // Every update code from pointer zero, so that decrements wrap
    task automatic test_codes();
        logic [2:0] c;
        wreg(STEP_OFS, 32'h0003);
        for (int i = 0; i < 8; i++) begin
            c = i[2:0];
            wreg(PTR_BASE_OFS, 32'h0);
            issue({8'h28, 1'b1, c, 4'h0}, 1'b1);
            dchk(8'h28, 1'b1, 16'h0000);
            if (c == CODE_RSVD) begin
                rchk("rsvd sel", STATUS_OFS, 32'h0300);
            end else begin
                rchk("code upd", PTR_BASE_OFS,
                     {16'h0, upd(c, 16'h0, 16'h3)});
            end
        end
    endtask : test_codes

    // Back-to-back reverse-carry adds walk the buffer in bit order
    task automatic test_bitrev();
        logic [7:0] seq [8] = '{8'h60, 8'h68, 8'h64, 8'h6c,
                                8'h62, 8'h6a, 8'h66, 8'h6e};
        wreg(8'h08, 32'h0060);
        wreg(STEP_OFS, 32'h0008);
        wreg(STATUS_OFS, 32'h0002);
        p.drive(16'h28f0, 1'b1);
        for (int i = 0; i < 9; i++) begin
            @(posedge aclk);
            if (i == 7) p.idle();
            if (i > 0) begin
                check("rc ind", {31'h0, indirect_access}, 32'h1);
                check("rc addr", {16'h0, mem_addr},
                      {24'h0, seq[i-1]});
            end
        end
        rchk("ptr2 end", 8'h08,
             {16'h0, upd(CODE_RC_ADD, 16'h006e, 16'h8)});
    endtask : test_bitrev

    task automatic test_nomem();
        issue(16'h5a0b, 1'b1);
        dchk(8'h5a, 1'b0, 16'h0);
        issue(16'h28ab, 1'b0);
        dchk(8'h28, 1'b0, 16'h0);
        rchk("sel kept", STATUS_OFS, 32'h0002);
        rchk("ptr2 kept", 8'h08, 32'h0061);
        rchk("last instr", LAST_INSTR_OFS, 32'h28ab);
    endtask : test_nomem

    initial begin
        error_cnt     = 0;
        n_tests       = 0;
        cycles        = 0;
        aresetn       = 1'b0;
        s_axi_awaddr  = 8'h00;
        s_axi_awvalid = 1'b0;
        s_axi_wdata   = 32'h0;
        s_axi_wstrb   = 4'h0;
        s_axi_wvalid  = 1'b0;
        s_axi_bready  = 1'b0;
        s_axi_araddr  = 8'h00;
        s_axi_arvalid = 1'b0;
        s_axi_rready  = 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        test_reset();
        test_encoding();
        test_codes();
        test_bitrev();
        test_nomem();
        stop_test();
    end
endmodule : tb_indirect_address_generator
`default_nettype wire
